// *** shared/serializer_link_defines.svh ***
`ifndef SERIALIZER_LINK_DEFINES_SVH
`define SERIALIZER_LINK_DEFINES_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define LINK_CONTROL_INDEX 8'h04
`define LINK_OUTPUT_CONFIG_INDEX 8'h05
`define LINK_STATUS_INDEX 8'h08

// ****************************************************************
// reset values
// ****************************************************************
// serial link and sleep bits are overwritten from the straps after release
`define LINK_CONTROL_RESET 8'h03
`define LINK_OUTPUT_CONFIG_RESET 8'h70

// ****************************************************************
// field codes
// ****************************************************************
`define PIF_I2C 2'b00
`define PIF_UART 2'b01
`define LEVEL_UNUSED 2'b00
`define PREEMPHASIS_SELECT_UNUSED_LO 4'h5
`define PREEMPHASIS_SELECT_UNUSED_HI 4'h7

// ****************************************************************
// status register bit positions
// ****************************************************************
`define ST_HOLDOFF_BIT 0
`define ST_REV_READY_BIT 1
`define ST_AUTO_START_BIT 2
`define ST_CTRL_DIR_BIT 3
`define ST_LEVEL_BAD_BIT 4
`define ST_PREEMPHASIS_SELECT_BAD_BIT 5

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_PS 5000
`define REV_HOLDOFF_US 350
// least time: round up to whole cycles
`define REV_HOLDOFF_CYCLES ((`REV_HOLDOFF_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// cycles after reset release before the synchronised straps are trusted
`define STRAP_SETTLE_CYCLES 3'd4

`endif

// *** shared/serializer_link_pkg.sv ***
package serializer_link_pkg;

    // ****************************************************************
    // register layouts, msb first
    // ****************************************************************
    typedef struct packed {
        logic serial_link_enable;
        logic config_link_enable;
        logic prbs_test_enable;
        logic sleep_mode;
        logic [1:0] peripheral_interface_select;
        logic reverse_channel_enable;
        logic forward_channel_enable;
    } link_control_t;

    typedef struct packed {
        logic address_send_method;
        logic filter_pll_disable;
        logic [1:0] output_level_select;
        logic [3:0] preemphasis_select;
    } output_config_t;

    // ****************************************************************
    // controls driven into the serializer
    // ****************************************************************
    typedef struct packed {
        logic serial_link_enable;
        logic config_link_enable;
        logic prbs_test_enable;
        logic sleep_mode;
        logic i2c_base_enable;
        logic uart_base_enable;
        logic reverse_channel_enable;
        logic reverse_holdoff;
        logic forward_channel_enable;
        logic address_send_method;
        logic filter_pll_disable;
        logic [1:0] output_level_select;
        logic [3:0] preemphasis_select;
    } link_outputs_t;

    // ahb data phase held from the address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic lane0;
        logic [7:0] index;
    } ahb_phase_t;

    typedef enum logic [2:0] {
        INIT_WAIT = 3'b001,
        INIT_LOAD = 3'b010,
        INIT_RUN = 3'b100
    } init_state_t;

endpackage

// *** design/strap_sync.sv ***
`timescale 1ns/10ps

module strap_sync #(
    parameter int unsigned WIDTH = 2
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    // a bit changes only once the second and third stages agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : o_level[i];
        end
    end

    // stage1 feeds stage2 only
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            o_level <= '0;
        end else begin
            stage1 <= i_pin;
            stage2 <= stage1;
            stage3 <= stage2;
            o_level <= next_level;
        end
    end

endmodule

// *** design/holdoff_timer.sv ***
`timescale 1ns/10ps

module holdoff_timer #(
    parameter int unsigned HOLD_CYCLES = 70000
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    output logic o_busy
);

    localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_busy;

    // a new start restarts the full interval
    always_comb begin
        next_count = count;
        next_busy = o_busy;
        if (i_start) begin
            next_count = CW'(HOLD_CYCLES - 1);
            next_busy = 1'b1;
        end else if (o_busy) begin
            if (count == '0) begin
                next_busy = 1'b0;
            end else begin
                next_count = count - 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count <= '0;
            o_busy <= 1'b0;
        end else begin
            count <= next_count;
            o_busy <= next_busy;
        end
    end

endmodule

// *** design/serializer_link_control_regs.sv ***
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "serializer_link_defines.svh"

// Functional notes
// - bit 7 enables serial link; powers up 0 if auto-start strap high, else 1
// - reverse channel unavailable for 350 us after link start or stop
// - bit 4 selects sleep; power-up value derived from both straps
// - bits 3:2 pick base interface: 00 I2C, 01 UART, 1x disabled; reset 00
// - bit 1 gates reverse channel reception; resets to 1
// - bit 0 gates forward channel sending; resets to 1
// - second register bit 7: 1 omits I2C register address; resets to 0
// - bits 5:4 choose 200/300/400 mV for 01/10/11; 00 unused; reset 11

module serializer_link_control_regs
    import serializer_link_pkg::*;
#(
    parameter int unsigned HOLDOFF_CYCLES = `REV_HOLDOFF_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_auto_start_strap,
    input wire logic i_control_direction_strap,
    output link_outputs_t o_link_ctrl
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    init_state_t init_state;
    init_state_t next_init_state;
    logic [2:0] settle_cnt;
    logic [2:0] next_settle_cnt;
    logic [1:0] strap_level;
    logic auto_start_strap;
    logic control_direction_strap;

    ahb_phase_t dphase;
    ahb_phase_t next_dphase;
    logic addr_take;
    logic wr_lane0;
    logic next_hreadyout;
    logic [31:0] next_hrdata;

    link_control_t link_control;
    link_control_t next_link_control;
    output_config_t link_output_config;
    output_config_t next_link_output_config;
    logic level_bad;
    logic next_level_bad;
    logic preemphasis_select_bad;
    logic next_preemphasis_select_bad;
    logic [7:0] status_view;

    logic link_change;
    logic holdoff_busy;
    link_outputs_t next_link_ctrl;

    // ****************************************************************
    // strap capture
    // ****************************************************************
    // straps are pins, so they cross into this clock first
    strap_sync #(
        .WIDTH(2)
    ) u_strap_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin({i_control_direction_strap, i_auto_start_strap}),
        .o_level(strap_level)
    );

    assign auto_start_strap = strap_level[0];
    assign control_direction_strap = strap_level[1];

    // wait until the synchroniser has settled, load once, then serve the bus
    always_comb begin
        next_init_state = init_state;
        next_settle_cnt = settle_cnt;
        case (init_state)
            INIT_WAIT: begin
                if (settle_cnt == `STRAP_SETTLE_CYCLES) begin
                    next_init_state = INIT_LOAD;
                end else begin
                    next_settle_cnt = settle_cnt + 3'd1;
                end
            end
            INIT_LOAD: begin
                next_init_state = INIT_RUN;
            end
            INIT_RUN: begin
                next_init_state = INIT_RUN;
            end
            default: begin
                next_init_state = INIT_WAIT;
            end
        endcase
    end

    // ****************************************************************
    // ahb-lite slave
    // ****************************************************************
    // address phase is taken only once the straps are loaded
    assign addr_take = (init_state == INIT_RUN) && i_hsel && i_htrans[1] && i_hready;

    // only lane 0 carries register data; upper lanes are ignored
    always_comb begin
        next_dphase = dphase;
        next_dphase.valid = addr_take;
        if (addr_take) begin
            next_dphase.write = i_hwrite;
            next_dphase.lane0 = (i_haddr[1:0] == 2'b00) && (i_haddr[31:10] == 22'h0);
            next_dphase.index = i_haddr[9:2];
        end
    end

    assign wr_lane0 = dphase.valid && dphase.write && dphase.lane0;

    // zero wait states; never stalls after init
    assign next_hreadyout = (next_init_state == INIT_RUN);

    // ****************************************************************
    // register file
    // ****************************************************************
    always_comb begin
        next_link_control = link_control;
        next_link_output_config = link_output_config;
        if (init_state == INIT_LOAD) begin
            next_link_control.serial_link_enable = ~auto_start_strap;
            // sleep only when both straps ask for a held-off start
            next_link_control.sleep_mode = control_direction_strap & auto_start_strap;
        end else if (wr_lane0) begin
            if (dphase.index == `LINK_CONTROL_INDEX) begin
                // every bit is stored as written next cycle and reaches the outputs one cycle later, reverse enable only outside the hold-off
                next_link_control = link_control_t'(i_hwdata[7:0]);
            end else if (dphase.index == `LINK_OUTPUT_CONFIG_INDEX) begin
                // unused codes are kept, only flagged below
                next_link_output_config = output_config_t'(i_hwdata[7:0]);
            end
        end
    end

    // sticky flags for unused codes; a new bad write wins over a clear
    always_comb begin
        next_level_bad = level_bad;
        next_preemphasis_select_bad = preemphasis_select_bad;
        if (wr_lane0 && dphase.index == `LINK_STATUS_INDEX) begin
            if (i_hwdata[`ST_LEVEL_BAD_BIT]) begin
                next_level_bad = 1'b0;
            end
            if (i_hwdata[`ST_PREEMPHASIS_SELECT_BAD_BIT]) begin
                next_preemphasis_select_bad = 1'b0;
            end
        end
        if (next_link_output_config.output_level_select == `LEVEL_UNUSED && wr_lane0 &&
            dphase.index == `LINK_OUTPUT_CONFIG_INDEX) begin
            next_level_bad = 1'b1;
        end
        if (next_link_output_config.preemphasis_select >= `PREEMPHASIS_SELECT_UNUSED_LO &&
            next_link_output_config.preemphasis_select <= `PREEMPHASIS_SELECT_UNUSED_HI && wr_lane0 &&
            dphase.index == `LINK_OUTPUT_CONFIG_INDEX) begin
            next_preemphasis_select_bad = 1'b1;
        end
    end

    // live view of the block's own state
    always_comb begin
        status_view = 8'h00;
        status_view[`ST_HOLDOFF_BIT] = holdoff_busy;
        status_view[`ST_REV_READY_BIT] = o_link_ctrl.reverse_channel_enable;
        status_view[`ST_AUTO_START_BIT] = auto_start_strap;
        status_view[`ST_CTRL_DIR_BIT] = control_direction_strap;
        status_view[`ST_LEVEL_BAD_BIT] = level_bad;
        status_view[`ST_PREEMPHASIS_SELECT_BAD_BIT] = preemphasis_select_bad;
    end

    // control and config read data built from next values so a write just before is seen; status uses current values
    always_comb begin
        next_hrdata = 32'h0;
        if (addr_take && !i_hwrite && i_haddr[31:10] == 22'h0) begin
            if (i_haddr[9:2] == `LINK_CONTROL_INDEX) begin
                next_hrdata = {24'h0, next_link_control};
            end else if (i_haddr[9:2] == `LINK_OUTPUT_CONFIG_INDEX) begin
                next_hrdata = {24'h0, next_link_output_config};
            end else if (i_haddr[9:2] == `LINK_STATUS_INDEX) begin
                next_hrdata = {24'h0, status_view};
            end
        end
    end

    // ****************************************************************
    // reverse channel hold-off
    // ****************************************************************
    // any start or stop, including the strap load, restarts the wait
    assign link_change = next_link_control.serial_link_enable != link_control.serial_link_enable;

    holdoff_timer #(
        .HOLD_CYCLES(HOLDOFF_CYCLES)
    ) u_holdoff_timer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(link_change),
        .o_busy(holdoff_busy)
    );

    // ****************************************************************
    // control outputs
    // ****************************************************************
    // one register stage; reverse traffic is masked while the wait runs
    always_comb begin
        next_link_ctrl.serial_link_enable = link_control.serial_link_enable;
        next_link_ctrl.config_link_enable = link_control.config_link_enable;
        next_link_ctrl.prbs_test_enable = link_control.prbs_test_enable;
        next_link_ctrl.sleep_mode = link_control.sleep_mode;
        next_link_ctrl.i2c_base_enable = link_control.peripheral_interface_select == `PIF_I2C;
        next_link_ctrl.uart_base_enable = link_control.peripheral_interface_select == `PIF_UART;
        next_link_ctrl.reverse_channel_enable = link_control.reverse_channel_enable & ~holdoff_busy;
        next_link_ctrl.reverse_holdoff = holdoff_busy;
        next_link_ctrl.forward_channel_enable = link_control.forward_channel_enable;
        next_link_ctrl.address_send_method = link_output_config.address_send_method;
        next_link_ctrl.filter_pll_disable = link_output_config.filter_pll_disable;
        next_link_ctrl.output_level_select = link_output_config.output_level_select;
        next_link_ctrl.preemphasis_select = link_output_config.preemphasis_select;
    end

    // ****************************************************************
    // state registers
    // ****************************************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            init_state <= INIT_WAIT;
            settle_cnt <= 3'd0;
            dphase <= '0;
            o_hreadyout <= 1'b0;
            o_hrdata <= 32'h0;
            o_hresp <= 1'b0;
            link_control <= link_control_t'(`LINK_CONTROL_RESET);
            link_output_config <= output_config_t'(`LINK_OUTPUT_CONFIG_RESET);
            level_bad <= 1'b0;
            preemphasis_select_bad <= 1'b0;
            o_link_ctrl <= '0;
        end else begin
            init_state <= next_init_state;
            settle_cnt <= next_settle_cnt;
            dphase <= next_dphase;
            o_hreadyout <= next_hreadyout;
            o_hrdata <= next_hrdata;
            o_hresp <= 1'b0; // always okay
            link_control <= next_link_control;
            link_output_config <= next_link_output_config;
            level_bad <= next_level_bad;
            preemphasis_select_bad <= next_preemphasis_select_bad;
            o_link_ctrl <= next_link_ctrl;
        end
    end

endmodule

// *** sim/deserializer_model.sv ***
`timescale 1ns/10ps

// ****************************************************************
// far-end receiver: sends reverse traffic when the serializer listens
// ****************************************************************
module deserializer_model
    import serializer_link_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_slow,
    input wire link_outputs_t i_link,
    output logic [15:0] o_reverse_sent
);
    logic [1:0] pace = 2'd0;
    // one driver only: the counter lives here and the port just shows it
    logic [15:0] sent_count = 16'h0;

    assign o_reverse_sent = sent_count;

    // slow mode sends only every fourth cycle; never during the hold-off
    always @(posedge i_clk) begin
        pace <= pace + 2'd1;
        if (i_link.serial_link_enable && i_link.reverse_channel_enable && !i_link.reverse_holdoff
            && (!i_slow || pace == 2'd0)) begin
            sent_count <= sent_count + 16'd1;
        end
    end
endmodule

// *** sim/serializer_link_control_regs_checker.sv ***
`timescale 1ns/10ps

module serializer_link_control_regs_checker
    import serializer_link_pkg::*;
#(
    parameter int unsigned HOLDOFF_CYCLES = 70000
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic i_auto_start_strap,
    input wire logic i_control_direction_strap,
    input wire link_outputs_t o_link_ctrl
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    logic [31:0] hold_count;
    logic [31:0] next_hold_count;

    // cycles the hold-off has stood; a restart in mid-count is not modelled
    always_comb begin
        next_hold_count = o_link_ctrl.reverse_holdoff ? hold_count + 32'h1 : 32'h0;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_count <= 32'h0;
        end else begin
            hold_count <= next_hold_count;
        end
    end

    // write address phase taken, then its data phase
    sequence s_wr(logic [31:0] a);
        i_hsel && i_htrans[1] && i_hready && i_hwrite && i_haddr == a ##1 1'b1;
    endsequence

    property p_init;
        $rose(o_hreadyout) |-> ##2 (o_link_ctrl.serial_link_enable == !i_auto_start_strap
            && o_link_ctrl.sleep_mode == (i_auto_start_strap && i_control_direction_strap)
            && o_link_ctrl.forward_channel_enable && o_link_ctrl.i2c_base_enable
            && o_link_ctrl.output_level_select == 2'b11 && o_link_ctrl.preemphasis_select == 4'h0);
    endproperty
    property p_hold_on;
        $changed(o_link_ctrl.serial_link_enable) |-> o_link_ctrl.reverse_holdoff;
    endproperty
    property p_hold_gate;
        o_link_ctrl.reverse_holdoff |-> !o_link_ctrl.reverse_channel_enable;
    endproperty
    property p_hold_len;
        $fell(o_link_ctrl.reverse_holdoff) |-> hold_count == HOLDOFF_CYCLES;
    endproperty
    property p_ctl;
        s_wr(32'h10) |-> ##2 (o_link_ctrl.serial_link_enable == $past(i_hwdata[7], 2)
            && o_link_ctrl.config_link_enable == $past(i_hwdata[6], 2)
            && o_link_ctrl.prbs_test_enable == $past(i_hwdata[5], 2)
            && o_link_ctrl.sleep_mode == $past(i_hwdata[4], 2));
    endproperty
    property p_pif;
        s_wr(32'h10) |-> ##2 (o_link_ctrl.i2c_base_enable == ($past(i_hwdata[3:2], 2) == 2'b00)
            && o_link_ctrl.uart_base_enable == ($past(i_hwdata[3:2], 2) == 2'b01));
    endproperty
    property p_gate;
        s_wr(32'h10) |-> ##2 (o_link_ctrl.forward_channel_enable == $past(i_hwdata[0], 2)
            && o_link_ctrl.reverse_channel_enable == ($past(i_hwdata[1], 2) && !o_link_ctrl.reverse_holdoff));
    endproperty
    property p_out;
        s_wr(32'h14) |-> ##2 ({o_link_ctrl.address_send_method, o_link_ctrl.filter_pll_disable,
            o_link_ctrl.output_level_select, o_link_ctrl.preemphasis_select} == $past(i_hwdata[7:0], 2));
    endproperty

    a_init: assert property (p_init) else $error("power-up controls wrong");
    a_hold_on: assert property (p_hold_on) else $error("no hold-off on link change");
    a_hold_gate: assert property (p_hold_gate) else $error("reverse open in hold-off");
    a_hold_len: assert property (p_hold_len) else $error("hold-off length wrong");
    a_ctl: assert property (p_ctl) else $error("link control bits wrong");
    a_pif: assert property (p_pif) else $error("interface select wrong");
    a_gate: assert property (p_gate) else $error("channel gates wrong");
    a_out: assert property (p_out) else $error("output config wrong");
endmodule

bind serializer_link_control_regs serializer_link_control_regs_checker #(
    .HOLDOFF_CYCLES(HOLDOFF_CYCLES)
) u_checker (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hwdata(i_hwdata),
    .i_hready(i_hready),
    .o_hreadyout(o_hreadyout),
    .i_auto_start_strap(i_auto_start_strap),
    .i_control_direction_strap(i_control_direction_strap),
    .o_link_ctrl(o_link_ctrl)
);

// *** sim/tb.sv ***
`timescale 1ns/10ps

module tb;
    import serializer_link_pkg::*;
    // short hold-off keeps the run brief
    localparam int unsigned HOLD = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic auto_strap = 1'b0;
    logic dir_strap = 1'b1;
    logic slow = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    link_outputs_t link;
    logic [15:0] sent;
    logic [15:0] snap;
    logic [31:0] rd;
    logic [7:0] d;
    int fail_count = 0;
    int check_count = 0;
    int n;

    always #2.5 clk = ~clk;

    serializer_link_control_regs #(.HOLDOFF_CYCLES(HOLD)) dut (
        .i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hreadyout),
        .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .i_auto_start_strap(auto_strap), .i_control_direction_strap(dir_strap), .o_link_ctrl(link)
    );

    deserializer_model far_end (.i_clk(clk), .i_slow(slow), .i_link(link), .o_reverse_sent(sent));

    // ****************************************************************
    // bus and compare tasks
    // ****************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one single transfer; waits on hready with no assumed latency
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= addr;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wdata;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        // an error response shows up as a mismatch on bit 31 of every read-data compare
        rd = hrdata | {hresp, 31'h0};
    endtask

    // count hold-off cycles and note far-end traffic meanwhile
    task automatic wait_hold;
        n = 0;
        snap = sent;
        while (link.reverse_holdoff === 1'b1 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // auto start low: link comes up and the hold-off runs
        bus(1'b0, 32'h10, 32'h0);
        check(rd, 32'h83);
        bus(1'b0, 32'h14, 32'h0);
        check(rd, 32'h70);
        #1;
        check(32'({link.reverse_holdoff, link.reverse_channel_enable}), 32'h2);
        wait_hold();
        check(32'(sent), 32'(snap));
        check(32'(link.reverse_channel_enable), 32'h1);
        // every interface code with the config, prbs, sleep and forward bits varied
        for (int c = 0; c < 4; c++) begin
            d = {1'b1, c[0], c[1], c[0] ^ c[1], c[1:0], 1'b1, ~c[0]};
            bus(1'b1, 32'h10, 32'(d));
            bus(1'b0, 32'h10, 32'h0);
            check(rd, 32'(d));
            #1;
            check(32'({link.config_link_enable, link.prbs_test_enable, link.sleep_mode, link.i2c_base_enable,
                link.uart_base_enable, link.forward_channel_enable}),
                32'({d[6:4], d[3:2] == 2'b00, d[3:2] == 2'b01, d[0]}));
        end
        // stop the link: reverse side stays shut for the full hold-off
        slow <= 1'b1;
        bus(1'b1, 32'h10, 32'h02);
        @(posedge clk);
        #1;
        check(32'({link.serial_link_enable, link.reverse_holdoff, link.reverse_channel_enable}), 32'h2);
        wait_hold();
        check(32'(n), 32'(HOLD));
        check(32'(link.reverse_channel_enable), 32'h1);
        bus(1'b1, 32'h10, 32'h82);
        @(posedge clk);
        #1;
        wait_hold();
        check(32'(sent), 32'(snap));
        repeat (8) @(posedge clk);
        #1;
        check(32'(sent > snap), 32'h1);
        // output levels, address method, pll and preemphasis codes incl. the unused preemphasis code 0110
        for (int i = 0; i < 4; i++) begin
            d = {i[0], i[1], 2'(i % 3 + 1), 4'(i * 5 + 1)};
            bus(1'b1, 32'h14, 32'(d));
            bus(1'b0, 32'h14, 32'h0);
            check(rd, 32'(d));
            #1;
            check(32'({link.address_send_method, link.filter_pll_disable, link.output_level_select,
                link.preemphasis_select}), 32'(d));
        end
        // unmapped write must leave the registers alone
        bus(1'b1, 32'h40, 32'hff);
        bus(1'b0, 32'h14, 32'h0);
        check(rd, 32'(d));
        bus(1'b0, 32'h40, 32'h0);
        check(rd, 32'h0);
        // status flags: code 0110 was stored above, a level of 00 raises the other flag
        bus(1'b0, 32'h20, 32'h0);
        check(rd, 32'h2a);
        bus(1'b1, 32'h20, 32'h20);
        bus(1'b1, 32'h14, 32'h00);
        bus(1'b0, 32'h20, 32'h0);
        check(rd, 32'h1a);
        // second reset with auto start high: link stays down, sleep set
        rst <= 1'b1;
        auto_strap <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 32'h10, 32'h0);
        check(rd, 32'h13);
        #1;
        check(32'({link.reverse_holdoff, link.reverse_channel_enable}), 32'h1);
        stop_test();
    end

    // hang guard, far beyond the expected run
    initial begin
        #(5 * 20000);
        fail_count++;
        stop_test();
    end
endmodule
